// ### src/ledsb_top.sv
// Two-wire write target and register bank for the LED driver
// Function
// R1 - Bytes are eight bits, MSB first, each followed by one acknowledge slot.
// R2 - Device pulls data low through the ninth clock after each byte.
// R3 - Master clocks the acknowledge slot and releases data high.
// R4 - First byte after start is seven-bit address plus write/read bit.
// R5 - Write: second byte picks register index, third byte is its value.
// R6 - Three registers at 10h, A0h, B0h, all cleared at reset.
// R7 - Enable bits 0, 1, 2 switch main, sub and keypad sinks.
// R8 - Low nibble sets main bank level, high nibble sub bank level.
// R9 - Display banks have sixteen PWM duty steps, 1/16 to full.
// R10 - PWM frequency is fixed by build option, not by registers.
// R11 - Keypad code picks 100, 70, 40 or 20 percent; 11 is full.
// R12 - Keypad register bits 7 to 2 are ignored.
// R13 - Keypad dims by analog level, with no PWM generator.
// R14 - Start is data falling with clock high; stop is data rising.
// R15 - Data changes only while clock is low, except start and stop.
// R16 - Keypad codes 10, 01, 00 give 70, 40, 20 percent.
// R17 - Master writes zeros to unused enable register bits.
// R18 - Register writes take effect only after the data byte is acked.
`timescale 1ns/1ps
`default_nettype none
`include "ledsb_defs.svh"
module ledsb_top #(
	parameter int PWM_PERIOD_CYC = `LEDSB_CLK_HZ / `LEDSB_PWM_HZ
) (
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 RST_I,
	input  wire logic                 CE_I,
	input  wire logic                 SCL_I,
	input  wire logic                 SDA_I,
	output logic                      SDA_O,
	output logic                      SDA_OE_O,
	output logic                      MAIN_BANK_SINKS_O,
	output logic                      SUB_BANK_SINKS_O,
	output logic                      KEYPAD_SINK_ON_O,
	output logic [1:0]                KEYPAD_LEVEL_O,
	output ledsb_pkg::ledsb_pct_t     KEYPAD_PCT_O,
	output logic [7:0]                GENERAL_ENABLE_O,
	output logic [7:0]                DISPLAY_BANK_BRIGHTNESS_O,
	output logic [7:0]                KEYPAD_BRIGHTNESS_O
);
	import ledsb_pkg::*;

	localparam int PWM_STEP_CYC = PWM_PERIOD_CYC / `LEDSB_PWM_STEPS;

	ledsb_ctl_t  s_q;
	ledsb_ctl_t  s_d;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_w;
	logic        stop_w;
	logic        commit_w;
	ledsb_pwm_if pif ();

	// Pins are synchronous; edges come from the previous sample
	assign scl_rise = !s_q.scl && SCL_I;
	assign scl_fall = s_q.scl && !SCL_I;
	assign start_w  = s_q.scl && SCL_I && s_q.sda && !SDA_I; // R14
	assign stop_w   = s_q.scl && SCL_I && !s_q.sda && SDA_I; // R14
	assign commit_w = (s_q.st == LEDSB_ACK) && scl_fall && (s_q.nbyte == `LEDSB_LAST_BYTE);

	always_comb begin
		s_d     = s_q;
		s_d.scl = SCL_I;
		s_d.sda = SDA_I;
		case (s_q.st)
			LEDSB_RX: begin
				if (scl_rise) begin
					s_d.shf  = {s_q.shf[6:0], SDA_I}; // R1
					s_d.bits = s_q.bits + 4'h1;
				end
				if (scl_fall && s_q.bits == `LEDSB_BYTE_BITS) begin // R1
					s_d.bits = 4'h0;
					case (s_q.nbyte)
						2'h0: begin
							if (s_q.shf[7:1] == `LEDSB_DEV_ADDR && !s_q.shf[0]) begin // R4
								s_d.st = LEDSB_ACK;
								s_d.oe = 1'b1; // R2
							end else begin
								// Reads are not served: leave the bus alone
								s_d.st = LEDSB_IGN;
							end
						end
						2'h1: begin
							s_d.idx = s_q.shf; // R5
							s_d.st  = LEDSB_ACK;
							s_d.oe  = 1'b1; // R2
						end
						default: begin
							s_d.dat = s_q.shf; // R5
							s_d.st  = LEDSB_ACK;
							s_d.oe  = 1'b1; // R2
						end
					endcase
				end
			end
			LEDSB_ACK: begin
				// Held low until the master ends the ninth pulse
				if (scl_fall) begin // R3
					s_d.oe = 1'b0;
					s_d.st = LEDSB_RX;
					if (s_q.nbyte != `LEDSB_LAST_BYTE) begin
						s_d.nbyte = s_q.nbyte + 2'h1;
					end
				end
			end
			LEDSB_IDLE, LEDSB_IGN: begin
				s_d.oe = 1'b0;
			end
			default: begin
				s_d.st = LEDSB_IDLE;
				s_d.oe = 1'b0;
			end
		endcase
		// Extra data bytes rewrite the same register
		if (commit_w) begin // R18
			case (s_q.idx) // R6
				`LEDSB_IDX_GEN:    s_d.gen  = s_q.dat; // R17
				`LEDSB_IDX_DISP:   s_d.disp = s_q.dat; // R8
				`LEDSB_IDX_KEYPAD: s_d.kp   = s_q.dat[`LEDSB_KP_W-1:0]; // R12
				default:           s_d.kp   = s_q.kp;
			endcase
		end
		// Repeated start behaves as a first start
		if (start_w) begin // R14
			s_d.st    = LEDSB_RX;
			s_d.bits  = 4'h0;
			s_d.nbyte = 2'h0;
			s_d.oe    = 1'b0;
		end else if (stop_w) begin // R14
			s_d.st = LEDSB_IDLE;
			s_d.oe = 1'b0;
		end
		// Analog current scale only, so no duty generator here
		case (s_q.kp) // R13
			2'h3:    s_d.kpct = `LEDSB_PCT_100; // R11
			2'h2:    s_d.kpct = `LEDSB_PCT_70; // R16
			2'h1:    s_d.kpct = `LEDSB_PCT_40; // R16
			default: s_d.kpct = `LEDSB_PCT_20; // R16
		endcase
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s_q <= '0; // R6
		end else if (CE_I) begin
			s_q <= s_d;
		end
	end

	assign pif.en[0]    = s_q.gen[`LEDSB_EN_MAIN]; // R7
	assign pif.en[1]    = s_q.gen[`LEDSB_EN_SUB]; // R7
	assign pif.level[0] = s_q.disp[`LEDSB_MAIN_LSB +: `LEDSB_LVL_W]; // R8
	assign pif.level[1] = s_q.disp[`LEDSB_SUB_LSB +: `LEDSB_LVL_W]; // R8

	ledsb_pwm #(
		.CNT_W    (16),
		.STEP_CYC (PWM_STEP_CYC)
	) u_pwm (
		.SYS_CLK_I (SYS_CLK_I),
		.RST_I     (RST_I),
		.CE_I      (CE_I),
		.pif       (pif)
	);

	assign SDA_O                     = 1'b0;
	assign SDA_OE_O                  = s_q.oe;
	assign MAIN_BANK_SINKS_O         = pif.sink[0];
	assign SUB_BANK_SINKS_O          = pif.sink[1];
	assign KEYPAD_SINK_ON_O          = s_q.gen[`LEDSB_EN_KEY]; // R7
	assign KEYPAD_LEVEL_O            = s_q.kp;
	assign KEYPAD_PCT_O              = s_q.kpct;
	assign GENERAL_ENABLE_O          = s_q.gen;
	assign DISPLAY_BANK_BRIGHTNESS_O = s_q.disp;
	assign KEYPAD_BRIGHTNESS_O       = {6'h00, s_q.kp};

	a_ack_after_byte: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R2
		(CE_I && s_q.st == LEDSB_RX && scl_fall && s_q.bits == `LEDSB_BYTE_BITS
			&& s_q.nbyte != 2'h0 && !start_w && !stop_w) |=> SDA_OE_O)
		else $error("No acknowledge after data byte");
	a_drive_only_ack: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R2
		SDA_OE_O |-> (s_q.st == LEDSB_ACK))
		else $error("Data line driven outside acknowledge slot");
	a_addr_mismatch: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R4
		(CE_I && s_q.st == LEDSB_RX && scl_fall && s_q.bits == `LEDSB_BYTE_BITS
			&& s_q.nbyte == 2'h0 && !start_w && !stop_w
			&& (s_q.shf[7:1] != `LEDSB_DEV_ADDR || s_q.shf[0]))
		|=> (!SDA_OE_O && s_q.st == LEDSB_IGN))
		else $error("Foreign address or read acknowledged");
	a_gen_commit: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R18
		(CE_I && commit_w && s_q.idx == `LEDSB_IDX_GEN)
		|=> (GENERAL_ENABLE_O == $past(s_q.dat)))
		else $error("Enable register not written on acknowledge");
	a_reg_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R18
		!(CE_I && commit_w) |=> ($stable(GENERAL_ENABLE_O)
			&& $stable(DISPLAY_BANK_BRIGHTNESS_O) && $stable(KEYPAD_BRIGHTNESS_O)))
		else $error("Register changed without completed write");
	a_kp_upper_zero: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R12
		KEYPAD_BRIGHTNESS_O[7:2] == 6'h00)
		else $error("Keypad unused bits not zero");
	a_kp_full_map: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R11
		(CE_I && s_q.kp == 2'h3) |=> (KEYPAD_PCT_O == `LEDSB_PCT_100))
		else $error("Keypad code 11 not full scale");
	a_kp_low_map: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R16
		(CE_I && s_q.kp == 2'h0) |=> (KEYPAD_PCT_O == `LEDSB_PCT_20))
		else $error("Keypad code 00 not twenty percent");
	a_stop_to_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R14
		(CE_I && stop_w && !start_w) |=> (s_q.st == LEDSB_IDLE && !SDA_OE_O))
		else $error("Stop did not return to idle");
	a_drive_clk_low: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R15
		$rose(SDA_OE_O) |-> !$past(SCL_I))
		else $error("Data line pulled while clock high");
	a_kp_mid_map: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R16
		(CE_I && s_q.kp == 2'h2) |=> (KEYPAD_PCT_O == `LEDSB_PCT_70))
		else $error("Keypad code 10 not seventy percent");
	a_disp_commit: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R8
		(CE_I && commit_w && s_q.idx == `LEDSB_IDX_DISP)
		|=> (DISPLAY_BANK_BRIGHTNESS_O == $past(s_q.dat)))
		else $error("Brightness register not written on acknowledge");
	a_kp_commit: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R12
		(CE_I && commit_w && s_q.idx == `LEDSB_IDX_KEYPAD)
		|=> (KEYPAD_LEVEL_O == $past(s_q.dat[`LEDSB_KP_W-1:0])))
		else $error("Keypad level not written on acknowledge");
endmodule : ledsb_top
`default_nettype wire

// ### include/ledsb_defs.svh
// Constants for the LED serial brightness controller
`ifndef LEDSB_DEFS_SVH
`define LEDSB_DEFS_SVH
`define LEDSB_IDX_GEN      8'h10
`define LEDSB_IDX_DISP     8'ha0
`define LEDSB_IDX_KEYPAD   8'hb0
`define LEDSB_RST_VAL      8'h00
`define LEDSB_KP_RST       2'h0
`define LEDSB_EN_MAIN      0
`define LEDSB_EN_SUB       1
`define LEDSB_EN_KEY       2
`define LEDSB_MAIN_LSB     0
`define LEDSB_SUB_LSB      4
`define LEDSB_LVL_W        4
`define LEDSB_KP_W         2
`define LEDSB_BYTE_BITS    4'h8
`define LEDSB_LAST_BYTE    2'h2
`define LEDSB_PWM_STEPS    16
`define LEDSB_CLK_HZ       100000000
`define LEDSB_PWM_HZ       10000
`define LEDSB_PCT_100      7'h64
`define LEDSB_PCT_70       7'h46
`define LEDSB_PCT_40       7'h28
`define LEDSB_PCT_20       7'h14
// Arbitrary target address, not taken from any part
`define LEDSB_DEV_ADDR     7'h2a
`endif

// ### include/ledsb_pkg.sv
// Types for the LED serial brightness controller
`default_nettype none
package ledsb_pkg;
	typedef logic [6:0] ledsb_pct_t;
	typedef enum logic [1:0] {
		LEDSB_IDLE = 2'h0,
		LEDSB_RX   = 2'h1,
		LEDSB_ACK  = 2'h2,
		LEDSB_IGN  = 2'h3
	} ledsb_st_t;
	typedef struct packed {
		ledsb_st_t  st;
		logic       scl;
		logic       sda;
		logic [3:0] bits;
		logic [7:0] shf;
		logic [1:0] nbyte;
		logic [7:0] idx;
		logic [7:0] dat;
		logic       oe;
		logic [7:0] gen;
		logic [7:0] disp;
		logic [1:0] kp;
		ledsb_pct_t kpct;
	} ledsb_ctl_t;
endpackage : ledsb_pkg
`default_nettype wire

// ### include/ledsb_pwm_if.sv
// Enables, levels and sink drives between controller and PWM
`timescale 1ns/1ps
`default_nettype none
interface ledsb_pwm_if;
	logic [1:0]      en;
	logic [1:0][3:0] level;
	logic [1:0]      sink;
	modport ctrl (output en, output level, input sink);
	modport pwm  (input en, input level, output sink);
endinterface : ledsb_pwm_if
`default_nettype wire

// ### src/ledsb_pwm.sv
// Sixteen-step PWM for the two display banks
`timescale 1ns/1ps
`default_nettype none
`include "ledsb_defs.svh"
module ledsb_pwm #(
	parameter int CNT_W    = 16,
	parameter int STEP_CYC = 625
) (
	input  wire logic SYS_CLK_I,
	input  wire logic RST_I,
	input  wire logic CE_I,
	ledsb_pwm_if.pwm  pif
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [3:0]       phase;
		logic [1:0]       sink;
	} ledsb_pwm_st_t;

	ledsb_pwm_st_t s_q;
	ledsb_pwm_st_t s_d;
	logic [1:0]    on_w;

	// Level L is on for phases 0..L, giving (L+1)/16 duty
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		assign on_w[ch] = pif.en[ch] && (s_q.phase <= pif.level[ch]); // R9 R7
	end

	always_comb begin
		s_d = s_q;
		if (s_q.cnt == CNT_W'(STEP_CYC - 1)) begin // R10
			s_d.cnt   = '0;
			s_d.phase = s_q.phase + 4'h1;
		end else begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
		end
		s_d.sink = on_w;
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s_q <= '0;
		end else if (CE_I) begin
			s_q <= s_d;
		end
	end

	assign pif.sink = s_q.sink;

	a_bank_off_dark: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R7
		(CE_I && !pif.en[0]) |=> !pif.sink[0])
		else $error("Main bank driven while disabled");
	a_full_scale_on: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R9
		(CE_I && pif.en[1] && pif.level[1] == 4'hf) |=> pif.sink[1])
		else $error("Sub bank dark at full scale");
	a_lowest_duty: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // R9
		(CE_I && pif.en[0] && pif.level[0] == 4'h0 && s_q.phase != 4'h0
			&& $stable(pif.level[0])) |=> !pif.sink[0])
		else $error("Lowest level on outside first phase");
endmodule : ledsb_pwm
`default_nettype wire

// ### testbench/ledsb_bus_master.sv
// Two-wire bus master model for the serial target
`timescale 1ns/1ps
`default_nettype none
module ledsb_bus_master (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Data moves a cycle after clock low, never while clock is high
	task automatic bit_io(input logic b, output logic seen);
		@(negedge clk_i) sda_o = b;
		repeat (2) @(negedge clk_i);
		scl_o = 1'b1;
		repeat (2) @(negedge clk_i);
		seen = sda_i;
		scl_o = 1'b0;
	endtask : bit_io
	// Also serves as repeated start: data is raised before the clock
	task automatic bus_start();
		@(negedge clk_i) sda_o = 1'b1;
		repeat (2) @(negedge clk_i);
		scl_o = 1'b1;
		repeat (2) @(negedge clk_i);
		sda_o = 1'b0;
		repeat (2) @(negedge clk_i);
		scl_o = 1'b0;
	endtask : bus_start
	task automatic bus_stop();
		@(negedge clk_i) sda_o = 1'b0;
		repeat (2) @(negedge clk_i);
		scl_o = 1'b1;
		repeat (2) @(negedge clk_i);
		sda_o = 1'b1;
		repeat (2) @(negedge clk_i);
	endtask : bus_stop
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : send_byte
endmodule : ledsb_bus_master
`default_nettype wire

// ### testbench/ledsb_top_tb.sv
// Self-checking bench for the LED serial brightness controller
`timescale 1ns/1ps
`default_nettype none
`include "ledsb_defs.svh"
module ledsb_top_tb;
	localparam int PER = 160;
	localparam logic [7:0] WA = {`LEDSB_DEV_ADDR, 1'b0};
	logic       sys_clk = 1'b0;
	logic       rst     = 1'b1;
	logic       ce      = 1'b1;
	logic       scl, m_sda, oe, sda_o, main_s, sub_s, kp_on;
	logic [1:0] kp_lvl;
	logic [6:0] kp_pct;
	logic [7:0] gen, disp, kp;
	int         n_errors = 0;
	int         n_tests  = 0;
	int         cyc      = 0;
	// Open-drain wire with pull-up: low if either party pulls
	wire        sda_w = m_sda & ~(oe & ~sda_o);
	always #5 sys_clk = ~sys_clk;
	ledsb_top #(.PWM_PERIOD_CYC(PER)) dut (.SYS_CLK_I(sys_clk), .RST_I(rst), .CE_I(ce),
		.SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(oe), .MAIN_BANK_SINKS_O(main_s),
		.SUB_BANK_SINKS_O(sub_s), .KEYPAD_SINK_ON_O(kp_on), .KEYPAD_LEVEL_O(kp_lvl),
		.KEYPAD_PCT_O(kp_pct), .GENERAL_ENABLE_O(gen), .DISPLAY_BANK_BRIGHTNESS_O(disp),
		.KEYPAD_BRIGHTNESS_O(kp));
	ledsb_bus_master m (.clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// Unacked address means index and data bytes must be ignored too
	task automatic wr(input logic [7:0] a, input logic [7:0] idx, input logic [7:0] d,
		input logic ok);
		logic k;
		m.bus_start();
		m.send_byte(a, k);
		chk("addr ack", {7'h0, ok}, {7'h0, k});
		m.send_byte(idx, k);
		chk("index ack", {7'h0, ok}, {7'h0, k});
		m.send_byte(d, k);
		chk("data ack", {7'h0, ok}, {7'h0, k});
		m.bus_stop();
	endtask : wr
	task automatic duty(input logic [7:0] em, input logic [7:0] es);
		logic [7:0] mc, sc;
		mc = 8'h0;
		sc = 8'h0;
		repeat (PER) begin
			@(negedge sys_clk);
			mc = mc + main_s;
			sc = sc + sub_s;
		end
		chk("main duty", em, mc);
		chk("sub duty", es, sc);
	endtask : duty
	// Two whole periods hold exactly two rising edges at a fixed rate
	task automatic rises(input logic [7:0] er);
		logic [7:0] n;
		logic       p;
		n = 8'h0;
		p = main_s;
		repeat (2 * PER) begin
			@(negedge sys_clk);
			n = n + {7'h0, main_s & ~p};
			p = main_s;
		end
		chk("main rises", er, n);
	endtask : rises
	task automatic t_reset();
		chk("gen reset", 8'h00, gen);
		chk("disp reset", 8'h00, disp);
		chk("kp reset", 8'h00, kp);
		repeat (2) @(negedge sys_clk);
		chk("kp pct reset", 8'h14, {1'b0, kp_pct});
	endtask : t_reset
	task automatic t_pwm();
		wr(WA, `LEDSB_IDX_GEN, 8'h07, 1'b1);
		chk("gen", 8'h07, gen);
		chk("kp on", 8'h01, {7'h0, kp_on});
		duty(8'd10, 8'd10);
		wr(WA, `LEDSB_IDX_DISP, 8'hf3, 1'b1);
		duty(8'd40, 8'd160);
		rises(8'd2);
		wr(WA, `LEDSB_IDX_GEN, 8'h02, 1'b1);
		duty(8'd0, 8'd160);
	endtask : t_pwm
	task automatic t_keypad();
		logic [6:0] pct [4];
		pct = '{7'h14, 7'h28, 7'h46, 7'h64};
		for (int c = 0; c < 4; c++) begin
			wr(WA, `LEDSB_IDX_KEYPAD, {6'h3f, c[1:0]}, 1'b1);
			chk("kp reg", {6'h0, c[1:0]}, kp);
			chk("kp level", {6'h0, c[1:0]}, {6'h0, kp_lvl});
			repeat (2) @(negedge sys_clk);
			chk("kp pct", {1'b0, pct[c]}, {1'b0, kp_pct});
		end
	endtask : t_keypad
	task automatic t_refuse();
		wr(WA | 8'h01, `LEDSB_IDX_GEN, 8'h55, 1'b0);
		wr(WA ^ 8'h02, `LEDSB_IDX_GEN, 8'h55, 1'b0);
		wr(WA, 8'h20, 8'h55, 1'b1);
		chk("gen kept", 8'h02, gen);
		chk("disp kept", 8'hf3, disp);
	endtask : t_refuse
	task automatic t_late();
		logic k;
		logic [7:0] d;
		d = 8'h05;
		m.bus_start();
		m.send_byte(WA, k);
		m.send_byte(`LEDSB_IDX_GEN, k);
		for (int i = 7; i >= 0; i--) m.bit_io(d[i], k);
		chk("gen before ack", 8'h02, gen);
		m.bit_io(1'b1, k);
		repeat (2) @(negedge sys_clk);
		chk("gen after ack", d, gen);
		m.bus_stop();
	endtask : t_late
	// Aborted write, repeated start, then two data bytes to one index
	task automatic t_restart();
		logic k;
		m.bus_start();
		m.send_byte(WA, k);
		m.send_byte(`LEDSB_IDX_DISP, k);
		m.bus_start();
		m.send_byte(WA, k);
		chk("restart ack", 8'h01, {7'h0, k});
		m.send_byte(`LEDSB_IDX_GEN, k);
		m.send_byte(8'h03, k);
		repeat (2) @(negedge sys_clk);
		chk("gen first", 8'h03, gen);
		m.send_byte(8'h06, k);
		chk("extra ack", 8'h01, {7'h0, k});
		repeat (2) @(negedge sys_clk);
		chk("gen extra", 8'h06, gen);
		m.bus_stop();
		chk("disp untouched", 8'hf3, disp);
	endtask : t_restart
	// A frozen target neither acknowledges nor stores
	task automatic t_freeze();
		ce = 1'b0;
		wr(WA, `LEDSB_IDX_GEN, 8'h01, 1'b0);
		ce = 1'b1;
		chk("frozen gen", 8'h06, gen);
	endtask : t_freeze
	// Reset in mid-run clears the bank and leaves the target usable
	task automatic t_rerst();
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		chk("gen rerst", 8'h00, gen);
		chk("disp rerst", 8'h00, disp);
		chk("kp rerst", 8'h00, kp);
		repeat (2) @(negedge sys_clk);
		chk("kp pct rerst", 8'h14, {1'b0, kp_pct});
		wr(WA, `LEDSB_IDX_GEN, 8'h04, 1'b1);
		chk("gen after rerst", 8'h04, gen);
		chk("kp on rerst", 8'h01, {7'h0, kp_on});
	endtask : t_rerst
	task automatic complete_run();
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// Whole run needs about 3050 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		t_reset();
		t_pwm();
		t_keypad();
		t_refuse();
		t_late();
		t_restart();
		t_freeze();
		t_rerst();
		complete_run();
	end
endmodule : ledsb_top_tb
`default_nettype wire
